// *** logic/dsad_pkg.sv ***
// Package: constants and carrier types for the satellite address discovery block
package dsad_pkg;
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS       = 40;
    localparam int unsigned CRM_READY_US        = 13500;  // 13.5 ms
    localparam int unsigned DISC_OPEN_US        = 5000;   // 5.0 ms
    localparam int unsigned DISC_CLOSE_US       = 13500;  // 13.5 ms
    localparam int unsigned CRM_READY_CYC       = (CRM_READY_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned DISC_OPEN_CYC       = (DISC_OPEN_US * 1000 + CLK_PERIOD_NS - 1)
                                                  / CLK_PERIOD_NS;
    localparam int unsigned DISC_CLOSE_CYC      = (DISC_CLOSE_US * 1000) / CLK_PERIOD_NS;
    // Discovery round timing defaults (cycles)
    localparam int unsigned RESP_DELAY_CYC      = 16;
    localparam int unsigned RAMP_CYC            = 32;
    localparam int unsigned HOLD_CYC            = 32;
    // Register map and command codes
    localparam logic [7:0] NODE_ADDRESS_OFS     = 8'h18;
    localparam logic [7:0] NODE_ADDRESS_RST     = 8'h00;
    localparam logic [3:0] CMD_GLOBAL_WRITE     = 4'h8;
    localparam logic [3:0] ADDR_CNT_RST         = 4'h1;
    localparam logic [3:0] FIRST_ADDRESS        = 4'h1;
    localparam int unsigned RAMP_W              = 8;
    localparam logic [7:0] RAMP_FULL            = 8'hFF;  // Full response level, reached at the end of the ramp

    // Decoded command-and-response write request
    typedef struct packed {
        logic       valid;
        logic [3:0] cmd;
        logic [7:0] addr;
        logic [7:0] data;
    } dsad_crm_req_t;

    // Discovery phase state
    typedef enum logic [4:0] {
        DSAD_IDLE  = 5'b00001,
        DSAD_WAIT  = 5'b00010,
        DSAD_RAMP  = 5'b00100,
        DSAD_HOLD  = 5'b01000,
        DSAD_DONE  = 5'b10000
    } dsad_state_t;
endpackage : dsad_pkg

// *** logic/dsad_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dsad_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic stage1;

    // First stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule : dsad_sync

// *** logic/dsad_satellite.sv ***
// Satellite side: discovery addressing, node address register and start-up windows
`timescale 1ns/1ns
module dsad_satellite
    import dsad_pkg::*;
#(
    parameter int unsigned CRM_READY  = CRM_READY_CYC,
    parameter int unsigned DISC_OPEN  = DISC_OPEN_CYC,
    parameter int unsigned DISC_CLOSE = DISC_CLOSE_CYC,
    parameter int unsigned RESP_DELAY = RESP_DELAY_CYC,
    parameter int unsigned RAMP_LEN   = RAMP_CYC,
    parameter int unsigned HOLD_LEN   = HOLD_CYC
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          disc_cmd,
    input  wire logic          sense_above,
    input  wire dsad_crm_req_t crm_req,
    output logic               crm_ready,
    output logic               disc_window,
    output logic [7:0]         resp_level,
    output logic               resp_on,
    output logic [7:0]         node_address,
    output logic               addr_valid,
    output logic [3:0]         addr_counter
);
    logic        disc_cmd_s;
    logic        sense_s;
    logic [23:0] por_cnt;
    logic [23:0] next_por_cnt;
    logic        next_crm_ready;
    logic        next_disc_window;
    dsad_state_t state;
    dsad_state_t next_state;
    logic [15:0] tmr;
    logic [15:0] next_tmr;
    logic [7:0]  next_resp_level;
    logic        next_resp_on;
    logic [7:0]  next_node_address;
    logic        next_addr_valid;
    logic [3:0]  next_addr_counter;
    logic        first_round;
    logic        next_first_round;
    logic        disc_prev;
    logic        disc_rise;

    // Pin inputs cross into the clock domain
    dsad_sync u_sync_cmd (
        .mclk (mclk),
        .rst  (rst),
        .din  (disc_cmd),
        .dout (disc_cmd_s)
    );
    dsad_sync u_sync_sense (
        .mclk (mclk),
        .rst  (rst),
        .din  (sense_above),
        .dout (sense_s)
    );

    assign disc_rise = disc_cmd_s & ~disc_prev;

    // Time since reset release; saturates to stop wrapping
    always_comb begin
        next_por_cnt     = por_cnt;
        if (por_cnt < 24'(DISC_CLOSE) || por_cnt < 24'(CRM_READY)) begin
            next_por_cnt = por_cnt + 24'h000001;
        end
        next_crm_ready   = (por_cnt >= 24'(CRM_READY));
        next_disc_window = (por_cnt >= 24'(DISC_OPEN)) && (por_cnt < 24'(DISC_CLOSE));
    end

    // Discovery sequencer and node address register
    always_comb begin
        next_state        = state;
        next_tmr          = tmr;
        next_resp_level   = resp_level;
        next_resp_on      = resp_on;
        next_node_address = node_address;
        next_addr_valid   = addr_valid;
        next_addr_counter = addr_counter;
        next_first_round  = first_round;
        case (state)
            DSAD_IDLE: begin
                // Addressed satellites stay silent
                if (disc_rise && disc_window && !addr_valid) begin
                    next_state = DSAD_WAIT;
                    next_tmr   = 16'h0000;
                end
            end
            DSAD_WAIT: begin
                next_tmr = tmr + 16'h0001;
                if (tmr >= 16'(RESP_DELAY - 1)) begin
                    next_state      = DSAD_RAMP;
                    next_tmr        = 16'h0000;
                    next_resp_on    = 1'b1;
                    next_resp_level = 8'h00;
                end
            end
            DSAD_RAMP: begin
                next_tmr        = tmr + 16'h0001;
                next_resp_level = 8'((32'(tmr) + 1) * 255 / RAMP_LEN);
                if (sense_s) begin
                    next_state        = DSAD_IDLE;
                    next_resp_on      = 1'b0;
                    next_resp_level   = 8'h00;
                    next_addr_counter = addr_counter + 4'h1;
                    next_first_round  = 1'b0;
                end else if (tmr >= 16'(RAMP_LEN - 1)) begin
                    next_state      = DSAD_HOLD;
                    next_tmr        = 16'h0000;
                    next_resp_level = RAMP_FULL;
                end
            end
            DSAD_HOLD: begin
                next_tmr = tmr + 16'h0001;
                if (sense_s) begin
                    next_state        = DSAD_IDLE;
                    next_resp_on      = 1'b0;
                    next_resp_level   = 8'h00;
                    next_addr_counter = addr_counter + 4'h1;
                    next_first_round  = 1'b0;
                end else if (tmr >= 16'(HOLD_LEN - 1)) begin
                    // Winner takes 1 first time, else its counter
                    next_node_address = first_round ? {4'h0, FIRST_ADDRESS}
                                                    : {4'h0, addr_counter};
                    next_addr_valid   = 1'b1;
                    next_resp_on      = 1'b0;
                    next_resp_level   = 8'h00;
                    next_state        = DSAD_DONE;
                end
            end
            DSAD_DONE: begin
                next_state = DSAD_DONE;
            end
            default: begin
                next_state = DSAD_IDLE;
            end
        endcase
        // Global write to the node address register; ignored before ready
        if (crm_req.valid && crm_ready && crm_req.cmd == CMD_GLOBAL_WRITE
            && crm_req.addr == NODE_ADDRESS_OFS) begin
            next_node_address = crm_req.data;
            next_addr_valid   = (crm_req.data != 8'h00);
            if (crm_req.data != 8'h00) begin
                next_state    = DSAD_DONE;
                next_resp_on  = 1'b0;
                next_resp_level = 8'h00;
            end
        end
    end

    // State registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            por_cnt      <= 24'h000000;
            crm_ready    <= 1'b0;
            disc_window  <= 1'b0;
            state        <= DSAD_IDLE;
            tmr          <= 16'h0000;
            resp_level   <= 8'h00;
            resp_on      <= 1'b0;
            node_address <= NODE_ADDRESS_RST;
            addr_valid   <= 1'b0;
            addr_counter <= ADDR_CNT_RST;
            first_round  <= 1'b1;
            disc_prev    <= 1'b0;
        end else begin
            por_cnt      <= next_por_cnt;
            crm_ready    <= next_crm_ready;
            disc_window  <= next_disc_window;
            state        <= next_state;
            tmr          <= next_tmr;
            resp_level   <= next_resp_level;
            resp_on      <= next_resp_on;
            node_address <= next_node_address;
            addr_valid   <= next_addr_valid;
            addr_counter <= next_addr_counter;
            first_round  <= next_first_round;
            disc_prev    <= disc_cmd_s;
        end
    end

    // Checks
    sequence s_lose;
        (state == DSAD_RAMP || state == DSAD_HOLD) && sense_s;
    endsequence

    a_addr_silent: assert property (@(posedge mclk) disable iff (rst)
        addr_valid |-> !resp_on && state == DSAD_DONE)
        else $error("addressed satellite drove response current");
    a_lose_count: assert property (@(posedge mclk) disable iff (rst)
        s_lose |=> !resp_on && addr_counter == $past(addr_counter) + 4'h1)
        else $error("lost round did not stop current and count");
    a_ramp_start: assert property (@(posedge mclk) disable iff (rst)
        state == DSAD_WAIT && tmr == 16'(RESP_DELAY - 1) |=> resp_on)
        else $error("ramp did not start after response delay");
    a_ramp_full: assert property (@(posedge mclk) disable iff (rst)
        state == DSAD_HOLD |-> resp_level == RAMP_FULL && resp_on)
        else $error("hold without full response level");
    a_first_win: assert property (@(posedge mclk) disable iff (rst)
        state == DSAD_HOLD && !sense_s && first_round && tmr == 16'(HOLD_LEN - 1)
        && !crm_req.valid |=> node_address == 8'h01 && !resp_on)
        else $error("first round winner did not take address one");
    a_later_win: assert property (@(posedge mclk) disable iff (rst)
        state == DSAD_HOLD && !sense_s && !first_round && tmr == 16'(HOLD_LEN - 1)
        && !crm_req.valid |=> node_address == {4'h0, $past(addr_counter)})
        else $error("later winner did not take counter value");
    a_crm_gate: assert property (@(posedge mclk) disable iff (rst)
        !crm_ready && state != DSAD_HOLD |=> $stable(node_address))
        else $error("node address written before ready");
    a_disc_window: assert property (@(posedge mclk) disable iff (rst)
        state == DSAD_IDLE && !disc_window |=> state != DSAD_WAIT)
        else $error("discovery answered outside window");
    a_ctr_reset: assert property (@(posedge mclk)
        $fell(rst) |-> addr_counter == ADDR_CNT_RST && node_address == 8'h00)
        else $error("counter or address wrong after reset");
endmodule : dsad_satellite

// *** testbench/dsad_ctrl_model.sv ***
// Bus controller model: discovery commands and global write frames
`timescale 1ns/1ns
module dsad_ctrl_model
    import dsad_pkg::*;
(
    input  wire logic mclk,
    output logic          disc_cmd,
    output dsad_crm_req_t crm_req
);
    // Segment starts quiet so the first command is a clean edge
    initial begin
        disc_cmd = 1'b0;
        crm_req  = '0;
    end
    // Held several cycles, long enough to cross the pin synchroniser
    task automatic send_disc();
        @(posedge mclk) disc_cmd <= 1'b1;
        repeat (4) @(posedge mclk);
        disc_cmd <= 1'b0;
    endtask : send_disc
    // Single-cycle frame, same domain as the satellite
    task automatic crm_write(input logic [3:0] cmd, input logic [7:0] adr, input logic [7:0] dat);
        @(posedge mclk) crm_req <= '{1'b1, cmd, adr, dat};
        @(posedge mclk) crm_req <= '0;
    endtask : crm_write
endmodule : dsad_ctrl_model

// *** testbench/dsi3_address_discovery_init_bench.sv ***
// Bench for the satellite: discovery rounds, start-up windows, address writes
`timescale 1ns/1ns
module dsi3_address_discovery_init_bench;
    import dsad_pkg::*;
    logic          mclk, rst, sense_above, disc_cmd, crm_ready, disc_window, resp_on, addr_valid;
    dsad_crm_req_t crm_req;
    logic [7:0]    resp_level, node_address, peak;
    logic [3:0]    addr_counter;
    int            mismatches, compares, cyc, por, exp_addr, exp_cnt, exp_valid, seen_on;

    // Response delay keeps its default so the full wait count is exercised
    dsad_satellite #(.CRM_READY(200), .DISC_OPEN(50), .DISC_CLOSE(150),
        .RAMP_LEN(8), .HOLD_LEN(8)) i_dsad_satellite (
        .mclk(mclk), .rst(rst), .disc_cmd(disc_cmd), .sense_above(sense_above),
        .crm_req(crm_req), .crm_ready(crm_ready), .disc_window(disc_window),
        .resp_level(resp_level), .resp_on(resp_on), .node_address(node_address),
        .addr_valid(addr_valid), .addr_counter(addr_counter));
    dsad_ctrl_model i_dsad_ctrl_model (.mclk(mclk), .disc_cmd(disc_cmd), .crm_req(crm_req));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Cycles since reset release, plus a hang limit
    always @(posedge mclk) begin
        por <= rst ? 0 : por + 1;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic wait_por(input int n);
        while (por < n) @(posedge mclk);
    endtask : wait_por
    task automatic regs(input string nm);
        check("node_address", node_address, exp_addr[7:0]);
        check("addr_valid", {7'h0, addr_valid}, exp_valid[7:0]);
        check("addr_counter", {4'h0, addr_counter}, exp_cnt[7:0]);
        $display("test %s done", nm);
    endtask : regs
    // Reset and reference model back to power-on values
    task automatic do_reset();
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        exp_addr = 0; exp_cnt = 1; exp_valid = 0;
        @(posedge mclk);
        check("crm_ready", {7'h0, crm_ready}, 8'h00);
        regs("reset");
    endtask : do_reset
    // One discovery round; lose pulls downstream current partway through the ramp, before it reaches full level
    task automatic round(input string nm, input bit lose, input bit open);
        int k, hold;
        seen_on = 0; peak = 8'h00;
        hold = $urandom_range(1, 4);
        fork i_dsad_ctrl_model.send_disc(); join_none
        for (k = 0; k < 40; k++) begin
            @(posedge mclk);
            if (resp_on === 1'b1) begin
                seen_on = 1;
                if (resp_level > peak) peak = resp_level;
                if (lose && hold-- == 0) sense_above <= 1'b1;
            end
        end
        sense_above <= 1'b0;
        check("resp_seen", seen_on[7:0], {7'h0, open && exp_valid == 0});
        check("resp_off", {7'h0, resp_on}, 8'h00);
        if (open && exp_valid == 0) begin
            check("peak_full", {7'h0, peak === RAMP_FULL}, {7'h0, !lose});
            if (lose) exp_cnt = (exp_cnt + 1) & 15;
            else begin
                exp_addr = exp_cnt;
                exp_valid = 1;
            end
        end
        regs(nm);
    endtask : round

    initial begin
        rst = 1'b1; sense_above = 1'b0; cyc = 0; por = 0; mismatches = 0; compares = 0;
        void'($urandom(67));
        do_reset();
        round("early", 1'b0, 1'b0);
        wait_por(52);
        round("lose", 1'b1, 1'b1);
        round("win_later", 1'b0, 1'b1);
        do_reset();
        wait_por(52);
        round("win_first", 1'b0, 1'b1);
        round("addressed", 1'b0, 1'b1);
        do_reset();
        wait_por(155);
        round("late", 1'b0, 1'b0);
        i_dsad_ctrl_model.crm_write(CMD_GLOBAL_WRITE, NODE_ADDRESS_OFS, 8'h5A);
        // A taken write would only show one edge after the frame ends
        @(posedge mclk);
        regs("crm_early");
        wait_por(202);
        check("crm_ready", {7'h0, crm_ready}, 8'h01);
        i_dsad_ctrl_model.crm_write(4'h9, NODE_ADDRESS_OFS, 8'h33);
        i_dsad_ctrl_model.crm_write(CMD_GLOBAL_WRITE, 8'h19, 8'h33);
        @(posedge mclk);
        regs("crm_refused");
        exp_addr = $urandom_range(1, 255);
        exp_valid = 1;
        i_dsad_ctrl_model.crm_write(CMD_GLOBAL_WRITE, NODE_ADDRESS_OFS, exp_addr[7:0]);
        @(posedge mclk);
        regs("crm_write");
        test_done();
    end
endmodule : dsi3_address_discovery_init_bench
